// file: rtl/atis_trigger_irq.v
// Purpose: scan start trigger routing and request generation for two units
// Assumes: APB slave, zero wait states; event inputs are one-cycle pulses
// Notes: status flags are write-one-to-clear; requests are registered
//
// Local design decisions: the address map and the APB slave port.
`timescale 1ns/10ps
`default_nettype none
`include "atis_defines.vh"
module atis_trigger_irq #(
  parameter GROUPS = 9,
  parameter TIMERS = 10,
  parameter CHANS = 29
) (
  input wire i_core_clk,
  input wire i_rst,
  input wire i_psel,
  input wire i_penable,
  input wire i_pwrite,
  input wire [`ATIS_ADDR_W-1:0] i_paddr,
  input wire [31:0] i_pwdata,
  output wire [31:0] o_prdata,
  output wire o_pready,
  output wire o_pslverr,
  input wire [TIMERS-1:0] i_timer_trigger_out_a,
  input wire [TIMERS-1:0] i_timer_trigger_out_b,
  input wire i_ext_trigger_pin_0_n,
  input wire i_ext_trigger_pin_1_n,
  input wire [1:0] i_unit_error,
  input wire [1:0] i_calibration_done,
  input wire [GROUPS-1:0] i_scan_done,
  input wire [7:0] i_limiter_table_clip,
  input wire [CHANS-1:0] i_limiter_channel_clip,
  input wire [8:0] i_limiter_extended_clip,
  input wire [1:0] i_result_overflow,
  input wire [CHANS-1:0] i_overflow_channel,
  input wire [8:0] i_overflow_extended,
  input wire [7:0] i_compare_table_match,
  input wire [GROUPS-1:0] i_fifo_overflow,
  input wire [GROUPS-1:0] i_fifo_full,
  input wire [4*GROUPS-1:0] i_fifo_vacant_count,
  output wire [GROUPS-1:0] o_scan_start,
  output wire [GROUPS-1:0] o_forced_stop,
  output wire [1:0] o_unit_error_irq,
  output wire [1:0] o_calibration_done_irq,
  output wire [4:0] o_scan_done_irq,
  output wire o_scan_done_shared_irq,
  output wire o_limiter_clip_irq,
  output wire [1:0] o_result_overflow_irq,
  output wire [3:0] o_compare_match_irq,
  output wire [1:0] o_composite_match_irq,
  output wire [4:0] o_fifo_read_request_irq,
  output wire o_fifo_read_request_shared_irq,
  output wire o_fifo_overflow_irq,
  output wire [21:0] o_event_link_fabric
);

  function [31:0] w1c;
    input [31:0] q;
    input [31:0] s;
    input [31:0] c;
    begin
      // set wins over a clear in the same cycle
      w1c = (q & ~c) | s;
    end
  endfunction

  function le4;
    input [3:0] vac;
    input [3:0] thr;
    begin
      le4 = (vac <= thr);
    end
  endfunction

  wire setup_ph = i_psel & ~i_penable;
  wire wr_acc = i_psel & i_penable & i_pwrite;

  function [31:0] clr_of;
    input [`ATIS_ADDR_W-1:0] a;
    begin
      clr_of = (wr_acc && (i_paddr == a)) ? i_pwdata : 32'h0000_0000;
    end
  endfunction

  reg [2*TIMERS-1:0] tsel_q [0:GROUPS-1];
  reg [31:0] trig_en_q;
  reg [31:0] irq_en_q;
  reg [31:0] fifo_en_q;
  reg [31:0] composite_q;
  reg [31:0] thr_lo_q;
  reg [31:0] thr_hi_q;
  reg [GROUPS-1:0] stop_pend_q;
  reg [GROUPS-1:0] stop_q;
  reg [1:0] uerr_q;
  reg [1:0] cald_q;
  reg [GROUPS-1:0] scan_q;
  reg [7:0] limt_q;
  reg [CHANS-1:0] limc_q;
  reg [8:0] limx_q;
  reg [1:0] rovf_q;
  reg [CHANS-1:0] ovfc_q;
  reg [8:0] ovfx_q;
  reg [7:0] cmpt_q;
  reg [GROUPS-1:0] fovf_q;
  reg [GROUPS-1:0] ffull_q;
  reg [GROUPS-1:0] start_q;
  reg [31:0] prdata_q;
  reg [21:0] evt_q;
  reg [21:0] irq_q;
  reg [31:0] rd_d;
  reg decode_ok;
  integer g;
  // separate loop index so the comb and clocked loops do not share a driver
  integer h;

  wire pin0_fall;
  wire pin1_fall;

  atis_pin_sync u_pin0 (
    .i_core_clk(i_core_clk),
    .i_rst(i_rst),
    .i_pin_n(i_ext_trigger_pin_0_n),
    .o_fall(pin0_fall)
  );

  atis_pin_sync u_pin1 (
    .i_core_clk(i_core_clk),
    .i_rst(i_rst),
    .i_pin_n(i_ext_trigger_pin_1_n),
    .o_fall(pin1_fall)
  );

  wire [2*TIMERS-1:0] timer_trig = {i_timer_trigger_out_b, i_timer_trigger_out_a};
  wire [GROUPS-1:0] ten_timer = trig_en_q[`ATIS_TEN_TIMER_LSB +: GROUPS];
  wire [GROUPS-1:0] ten_pin0 = trig_en_q[`ATIS_TEN_PIN0_LSB +: GROUPS];
  wire [GROUPS-1:0] ten_pin1 = trig_en_q[`ATIS_TEN_PIN1_LSB +: GROUPS];

  // done after forced stop is dropped
  wire [GROUPS-1:0] scan_set = i_scan_done & ~stop_pend_q;

  // sticky flags, write one to clear
  wire [31:0] uerr_n = w1c({30'h0, uerr_q}, {30'h0, i_unit_error}, clr_of(`ATIS_OFF_UERR));
  wire [31:0] cald_n = w1c({30'h0, cald_q}, {30'h0, i_calibration_done},
                           clr_of(`ATIS_OFF_CALD));
  wire [31:0] scan_n = w1c({23'h0, scan_q}, {23'h0, scan_set}, clr_of(`ATIS_OFF_SCAN));
  wire [31:0] limt_n = w1c({24'h0, limt_q}, {24'h0, i_limiter_table_clip},
                           clr_of(`ATIS_OFF_LIMT));
  wire [31:0] limc_n = w1c({3'h0, limc_q}, {3'h0, i_limiter_channel_clip},
                           clr_of(`ATIS_OFF_LIMC));
  wire [31:0] limx_n = w1c({23'h0, limx_q}, {23'h0, i_limiter_extended_clip},
                           clr_of(`ATIS_OFF_LIMX));
  wire [31:0] rovf_n = w1c({30'h0, rovf_q}, {30'h0, i_result_overflow},
                           clr_of(`ATIS_OFF_ROVF));
  wire [31:0] ovfc_n = w1c({3'h0, ovfc_q}, {3'h0, i_overflow_channel}, clr_of(`ATIS_OFF_OVFC));
  wire [31:0] ovfx_n = w1c({23'h0, ovfx_q}, {23'h0, i_overflow_extended},
                           clr_of(`ATIS_OFF_OVFX));
  wire [31:0] cmpt_n = w1c({24'h0, cmpt_q}, {24'h0, i_compare_table_match},
                           clr_of(`ATIS_OFF_CMPT));
  wire [31:0] ferr_n = w1c({7'h0, ffull_q, 7'h0, fovf_q}, {7'h0, i_fifo_full, 7'h0, i_fifo_overflow},
                           clr_of(`ATIS_OFF_FERR));

  wire [7:0] cmask0 = composite_q[7:0];
  wire [7:0] cmask1 = composite_q[15:8];
  wire comp0 = composite_q[`ATIS_CMP_MODE0_BIT] ?
               ((cmask0 != 8'h00) && ((cmpt_q & cmask0) == cmask0)) : (|(cmpt_q & cmask0));
  wire comp1 = composite_q[`ATIS_CMP_MODE1_BIT] ?
               ((cmask1 != 8'h00) && ((cmpt_q & cmask1) == cmask1)) : (|(cmpt_q & cmask1));

  // vacant count at or below threshold
  wire [4*GROUPS-1:0] thr_all = {thr_hi_q[3:0], thr_lo_q};
  reg [GROUPS-1:0] fifo_low;
  always @* begin
    fifo_low = {GROUPS{1'b0}};
    for (h = 0; h < GROUPS; h = h + 1) begin
      fifo_low[h] = le4(i_fifo_vacant_count[4*h +: 4], thr_all[4*h +: 4]);
    end
  end
  wire [GROUPS-1:0] fifo_req_src = fifo_low & ~ffull_q;
  wire [GROUPS-1:0] fifo_ie = fifo_en_q[GROUPS-1:0];

  // one source vector for both outputs
  wire [21:0] src = {
    |fovf_q,                 // 21 fifo overflow
    |fifo_req_src[8:5],      // 20 shared fifo request
    fifo_req_src[4:0],       // 19:15
    comp1, comp0,            // 14:13
    cmpt_q[3:0],             // 12:9
    rovf_q,                  // 8:7
    |limt_q,                 // 6
    |scan_q[8:5],            // 5
    scan_q[4:0]              // 4:0
  };
  wire [21:0] ena = {
    |fifo_ie,
    |fifo_ie[8:5],
    fifo_ie[4:0],
    irq_en_q[21:20],
    irq_en_q[`ATIS_IE_CMP_LSB +: 4],
    irq_en_q[`ATIS_IE_ROVF_LSB +: 2],
    irq_en_q[`ATIS_IE_LIM_BIT],
    |irq_en_q[`ATIS_IE_SCAN_LSB + 5 +: 4],
    irq_en_q[`ATIS_IE_SCAN_LSB +: 5]
  };
  // the overflow term needs a per-group enable, so it is refined here
  wire [21:0] gated = {|(fovf_q & fifo_ie), |(fifo_req_src[8:5] & fifo_ie[8:5]), src[19:0] & ena[19:0]};

  wire [1:0] err_irq_d = uerr_q & irq_en_q[`ATIS_IE_ERR_LSB +: 2];
  wire [1:0] cal_irq_d = cald_q & irq_en_q[`ATIS_IE_CAL_LSB +: 2];
  reg [3:0] unit_irq_q;
  reg [3:0] unit_evt_q;

  always @* begin
    rd_d = 32'h0000_0000;
    decode_ok = 1'b1;
    if (i_paddr < (`ATIS_OFF_TSEL0 + 12'h024)) begin
      rd_d = {{(32-2*TIMERS){1'b0}}, tsel_q[i_paddr[5:2]]};
      decode_ok = (i_paddr[1:0] == 2'b00);
    end else begin
      case (i_paddr)
        `ATIS_OFF_TRIG_EN: rd_d = trig_en_q;
        `ATIS_OFF_STOP: rd_d = {23'h0, stop_pend_q};
        `ATIS_OFF_UERR: rd_d = {30'h0, uerr_q};
        `ATIS_OFF_CALD: rd_d = {30'h0, cald_q};
        `ATIS_OFF_SCAN: rd_d = {23'h0, scan_q};
        `ATIS_OFF_LIMT: rd_d = {24'h0, limt_q};
        `ATIS_OFF_LIMC: rd_d = {3'h0, limc_q};
        `ATIS_OFF_LIMX: rd_d = {23'h0, limx_q};
        `ATIS_OFF_ROVF: rd_d = {30'h0, rovf_q};
        `ATIS_OFF_OVFC: rd_d = {3'h0, ovfc_q};
        `ATIS_OFF_OVFX: rd_d = {23'h0, ovfx_q};
        `ATIS_OFF_CMPT: rd_d = {24'h0, cmpt_q};
        `ATIS_OFF_FERR: rd_d = {7'h0, ffull_q, 7'h0, fovf_q};
        `ATIS_OFF_IRQ_EN: rd_d = irq_en_q;
        `ATIS_OFF_FIFO_EN: rd_d = fifo_en_q;
        `ATIS_OFF_COMPOSITE: rd_d = composite_q;
        `ATIS_OFF_THR_LO: rd_d = thr_lo_q;
        `ATIS_OFF_THR_HI: rd_d = thr_hi_q;
        default: decode_ok = 1'b0;
      endcase
    end
  end

  always @(posedge i_core_clk) begin
    if (i_rst) begin
      for (g = 0; g < GROUPS; g = g + 1) begin
        tsel_q[g] <= {2*TIMERS{1'b0}};
      end
      trig_en_q <= `ATIS_RST_WORD;
      irq_en_q <= `ATIS_RST_WORD;
      fifo_en_q <= `ATIS_RST_WORD;
      composite_q <= `ATIS_RST_WORD;
      thr_lo_q <= `ATIS_RST_THR_LO;
      thr_hi_q <= `ATIS_RST_THR_HI;
      prdata_q <= `ATIS_RST_WORD;
    end else begin
      // read data is captured in the setup cycle so it comes from a flop
      if (setup_ph) begin
        prdata_q <= rd_d;
      end
      if (wr_acc && decode_ok) begin
        if (i_paddr < (`ATIS_OFF_TSEL0 + 12'h024)) begin
          tsel_q[i_paddr[5:2]] <= i_pwdata[2*TIMERS-1:0];
        end
        case (i_paddr)
          `ATIS_OFF_TRIG_EN: trig_en_q <= i_pwdata;
          `ATIS_OFF_IRQ_EN: irq_en_q <= i_pwdata;
          `ATIS_OFF_FIFO_EN: fifo_en_q <= i_pwdata;
          `ATIS_OFF_COMPOSITE: composite_q <= i_pwdata;
          `ATIS_OFF_THR_LO: thr_lo_q <= i_pwdata;
          `ATIS_OFF_THR_HI: thr_hi_q <= i_pwdata;
          default: prdata_q <= prdata_q;
        endcase
      end
    end
  end

  wire [31:0] stop_all = clr_of(`ATIS_OFF_STOP);
  wire [GROUPS-1:0] stop_wr = stop_all[GROUPS-1:0];

  always @(posedge i_core_clk) begin
    if (i_rst) begin
      stop_pend_q <= {GROUPS{1'b0}};
      stop_q <= {GROUPS{1'b0}};
      uerr_q <= 2'b00;
      cald_q <= 2'b00;
      scan_q <= {GROUPS{1'b0}};
      limt_q <= 8'h00;
      limc_q <= {CHANS{1'b0}};
      limx_q <= 9'h000;
      rovf_q <= 2'b00;
      ovfc_q <= {CHANS{1'b0}};
      ovfx_q <= 9'h000;
      cmpt_q <= 8'h00;
      fovf_q <= {GROUPS{1'b0}};
      ffull_q <= {GROUPS{1'b0}};
      start_q <= {GROUPS{1'b0}};
      irq_q <= 22'h000000;
      evt_q <= 22'h000000;
      unit_irq_q <= 4'h0;
      unit_evt_q <= 4'h0;
    end else begin
      // stop pending until the group ends
      stop_pend_q <= (stop_pend_q & ~i_scan_done) | stop_wr;
      stop_q <= stop_wr;
      uerr_q <= uerr_n[1:0];
      cald_q <= cald_n[1:0];
      scan_q <= scan_n[GROUPS-1:0];
      limt_q <= limt_n[7:0];
      limc_q <= limc_n[CHANS-1:0];
      limx_q <= limx_n[8:0];
      rovf_q <= rovf_n[1:0];
      ovfc_q <= ovfc_n[CHANS-1:0];
      ovfx_q <= ovfx_n[8:0];
      cmpt_q <= cmpt_n[7:0];
      fovf_q <= ferr_n[GROUPS-1:0];
      ffull_q <= ferr_n[`ATIS_FERR_FULL_LSB +: GROUPS];
      for (g = 0; g < GROUPS; g = g + 1) begin
        start_q[g] <= (ten_timer[g] & (|(tsel_q[g] & timer_trig)))
                      | (ten_pin0[g] & pin0_fall) | (ten_pin1[g] & pin1_fall);
      end
      irq_q <= gated;
      // event outputs follow the flags, not the cpu enables
      evt_q <= {|fovf_q, src[20:0]};
      unit_irq_q <= {cal_irq_d, err_irq_d};
      unit_evt_q <= {cald_q, uerr_q};
    end
  end

  assign o_prdata = prdata_q;
  assign o_pready = 1'b1;
  assign o_pslverr = i_psel & i_penable & ~decode_ok;
  assign o_scan_start = start_q;
  assign o_forced_stop = stop_q;
  assign o_unit_error_irq = unit_irq_q[1:0];
  assign o_calibration_done_irq = unit_irq_q[3:2];
  assign o_scan_done_irq = irq_q[4:0];
  assign o_scan_done_shared_irq = irq_q[5];
  assign o_limiter_clip_irq = irq_q[6];
  assign o_result_overflow_irq = irq_q[8:7];
  assign o_compare_match_irq = irq_q[12:9];
  assign o_composite_match_irq = irq_q[14:13];
  assign o_fifo_read_request_irq = irq_q[19:15];
  assign o_fifo_read_request_shared_irq = irq_q[20];
  assign o_fifo_overflow_irq = irq_q[21];
  assign o_event_link_fabric = {evt_q[21:9], unit_evt_q, evt_q[8:4]} | {17'h0, evt_q[4:0] & 5'h00};

endmodule // atis_trigger_irq
`default_nettype wire

// file: rtl/atis_defines.vh
// Purpose: constants for the converter trigger and request block
// Assumes: APB byte addresses, one 32-bit word per register
// Notes: address width, offsets, field positions and reset values only
`ifndef ATIS_DEFINES_VH
`define ATIS_DEFINES_VH

`define ATIS_ADDR_W 12
// timer_trigger_select for group g sits at offset 4*g
`define ATIS_OFF_TSEL0 12'h000
`define ATIS_OFF_TRIG_EN 12'h024
`define ATIS_OFF_STOP 12'h028
`define ATIS_OFF_UERR 12'h030
`define ATIS_OFF_CALD 12'h034
`define ATIS_OFF_SCAN 12'h038
`define ATIS_OFF_LIMT 12'h03C
`define ATIS_OFF_LIMC 12'h040
`define ATIS_OFF_LIMX 12'h044
`define ATIS_OFF_ROVF 12'h048
`define ATIS_OFF_OVFC 12'h04C
`define ATIS_OFF_OVFX 12'h050
`define ATIS_OFF_CMPT 12'h054
`define ATIS_OFF_FERR 12'h058
`define ATIS_OFF_IRQ_EN 12'h060
`define ATIS_OFF_FIFO_EN 12'h064
`define ATIS_OFF_COMPOSITE 12'h068
`define ATIS_OFF_THR_LO 12'h06C
`define ATIS_OFF_THR_HI 12'h070

// trigger_source_enable fields
`define ATIS_TEN_TIMER_LSB 0
`define ATIS_TEN_PIN0_LSB 9
`define ATIS_TEN_PIN1_LSB 18
// irq enable fields
`define ATIS_IE_ERR_LSB 0
`define ATIS_IE_CAL_LSB 2
`define ATIS_IE_SCAN_LSB 4
`define ATIS_IE_LIM_BIT 13
`define ATIS_IE_ROVF_LSB 14
`define ATIS_IE_CMP_LSB 16
// fifo error status fields
`define ATIS_FERR_FULL_LSB 16
// composite fields: mask0 [7:0], mask1 [15:8], all-of mode bits 16 and 17
`define ATIS_CMP_MODE0_BIT 16
`define ATIS_CMP_MODE1_BIT 17

`define ATIS_RST_WORD 32'h0000_0000
`define ATIS_RST_THR_LO 32'h0000_0000
`define ATIS_RST_THR_HI 32'h0000_0000

`endif

// file: rtl/atis_pin_sync.v
// Purpose: synchronise one active-low trigger pin, flag its falling edge
// Assumes: pin idles high
// Notes: three stages; a change counts once stages two and three agree
`timescale 1ns/10ps
`default_nettype none
module atis_pin_sync (
  input wire i_core_clk,
  input wire i_rst,
  input wire i_pin_n,
  output wire o_fall
);
  reg s1_q;
  reg s2_q;
  reg s3_q;
  reg level_q;
  reg fall_q;
  always @(posedge i_core_clk) begin
    if (i_rst) begin
      s1_q <= 1'b1;
      s2_q <= 1'b1;
      s3_q <= 1'b1;
      level_q <= 1'b1;
      fall_q <= 1'b0;
    end else begin
      s1_q <= i_pin_n;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q) begin
        level_q <= s3_q;
      end
      fall_q <= level_q & ~s3_q & ~s2_q;
    end
  end
  assign o_fall = fall_q;
endmodule // atis_pin_sync
`default_nettype wire

// file: sim/atis_trigger_irq_monitor.sv
// Purpose: port-level checks of the trigger and request block
// Assumes: bound into atis_trigger_irq
// Notes: enables are internal, so outputs are tied to their causes
`timescale 1ns/10ps
`default_nettype none
`include "atis_defines.vh"
module atis_trigger_irq_monitor #(
  parameter GROUPS = 9,
  parameter TIMERS = 10
) (
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [`ATIS_ADDR_W-1:0] i_paddr,
  input wire logic [TIMERS-1:0] i_timer_trigger_out_a,
  input wire logic [TIMERS-1:0] i_timer_trigger_out_b,
  input wire logic i_ext_trigger_pin_0_n,
  input wire logic i_ext_trigger_pin_1_n,
  input wire logic [1:0] i_unit_error,
  input wire logic [GROUPS-1:0] i_scan_done,
  input wire logic [GROUPS-1:0] i_fifo_full,
  input wire logic [GROUPS-1:0] i_fifo_overflow,
  input wire logic [GROUPS-1:0] o_scan_start,
  input wire logic [GROUPS-1:0] o_forced_stop,
  input wire logic [1:0] o_unit_error_irq,
  input wire logic o_scan_done_shared_irq,
  input wire logic [4:0] o_fifo_read_request_irq,
  input wire logic o_fifo_overflow_irq
);
  wire wr_acc = i_psel & i_penable & i_pwrite;
  logic [3:0] pin_age_q;
  // pin falls reach the start output only after the synchroniser delay
  always @(posedge i_core_clk) begin
    if (i_rst) pin_age_q <= 4'hF;
    else if (!i_ext_trigger_pin_0_n || !i_ext_trigger_pin_1_n) pin_age_q <= 4'h0;
    else if (pin_age_q != 4'hF) pin_age_q <= pin_age_q + 4'h1;
  end
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_rst);
  a_start_has_cause: assert property (
    o_scan_start != '0 |-> $past(|{i_timer_trigger_out_a, i_timer_trigger_out_b})
    || pin_age_q < 4'hA) else $error("scan start without trigger");
  a_err_rise_cause: assert property (
    $rose(o_unit_error_irq[0]) |-> $past(i_unit_error[0], 2) || $past(i_unit_error[0])
    || $past(wr_acc) || $past(wr_acc, 2)) else $error("error request without cause");
  a_err_flag_holds: assert property (
    $fell(o_unit_error_irq[0]) |-> $past(wr_acc) || $past(wr_acc, 2))
    else $error("error request dropped without write");
  a_shared_rise_cause: assert property (
    $rose(o_scan_done_shared_irq) |-> $past(|i_scan_done[8:5], 2) || $past(|i_scan_done[8:5])
    || $past(wr_acc) || $past(wr_acc, 2)) else $error("shared scan request without cause");
  a_shared_flag_holds: assert property (
    $fell(o_scan_done_shared_irq) |-> $past(wr_acc) || $past(wr_acc, 2))
    else $error("shared scan request dropped without write");
  a_stop_from_write: assert property (
    o_forced_stop != '0 |-> $past(wr_acc) && $past(i_paddr) == `ATIS_OFF_STOP)
    else $error("stop pulse without stop write");
  a_full_withholds: assert property (
    i_fifo_full[0] |=> ##1 !o_fifo_read_request_irq[0])
    else $error("read request while fifo full");
  a_ovf_rise_cause: assert property (
    $rose(o_fifo_overflow_irq) |-> $past(|i_fifo_overflow, 2) || $past(|i_fifo_overflow)
    || $past(wr_acc) || $past(wr_acc, 2)) else $error("overflow request without cause");
  c_start: cover property (o_scan_start != '0);
  c_shared: cover property (o_scan_done_shared_irq);
  c_fifo_req: cover property (o_fifo_read_request_irq[0]);
endmodule // atis_trigger_irq_monitor
`default_nettype wire

// file: sim/atis_far_model.sv
// Purpose: timer trigger outputs and trigger pins facing the block
// Assumes: timers share the block clock
// Notes: pins idle high; timers pulse for one cycle on request
`timescale 1ns/10ps
`default_nettype none
module atis_far_model #(
  parameter TIMERS = 10
) (
  input wire logic i_core_clk,
  output var logic [TIMERS-1:0] o_trig_a,
  output var logic [TIMERS-1:0] o_trig_b,
  output var logic o_pin0_n,
  output var logic o_pin1_n
);
  initial begin
    o_trig_a = '0;
    o_trig_b = '0;
    o_pin0_n = 1'b1;
    o_pin1_n = 1'b1;
  end
  task automatic pulse(input logic use_b, input int idx);
    @(posedge i_core_clk);
    if (use_b) o_trig_b[idx] <= 1'b1;
    else o_trig_a[idx] <= 1'b1;
    @(posedge i_core_clk);
    o_trig_a <= '0;
    o_trig_b <= '0;
  endtask
  task automatic pin(input int k, input logic lvl);
    @(posedge i_core_clk);
    if (k == 0) o_pin0_n <= lvl;
    else o_pin1_n <= lvl;
  endtask
endmodule // atis_far_model
`default_nettype wire

// file: sim/atis_trigger_irq_test.sv
// Purpose: register and request checks of the trigger and request block
// Assumes: APB slave answers in the access phase
// Notes: status pulses come from the bench, triggers from the far model
`timescale 1ns/10ps
`default_nettype none
`include "atis_defines.vh"
module atis_trigger_irq_test;
  logic i_core_clk = 1'b0, i_rst = 1'b1, i_psel = 1'b0, i_penable = 1'b0, i_pwrite = 1'b0;
  logic [11:0] i_paddr = '0;
  logic [31:0] i_pwdata = '0, rd;
  logic [1:0] i_unit_error = '0, i_calibration_done = '0, i_result_overflow = '0;
  logic [8:0] i_scan_done = '0, i_limiter_extended_clip = '0, i_overflow_extended = '0;
  logic [8:0] i_fifo_overflow = '0, i_fifo_full = '0, last_start = '0, last_stop = '0;
  logic [7:0] i_limiter_table_clip = '0, i_compare_table_match = '0;
  logic [28:0] i_limiter_channel_clip = '0, i_overflow_channel = '0;
  logic [35:0] i_fifo_vacant_count = {9{4'hF}};
  logic se;
  wire [9:0] i_timer_trigger_out_a, i_timer_trigger_out_b;
  wire i_ext_trigger_pin_0_n, i_ext_trigger_pin_1_n, o_pready, o_pslverr, o_scan_done_shared_irq;
  wire o_limiter_clip_irq, o_fifo_read_request_shared_irq, o_fifo_overflow_irq;
  wire [31:0] o_prdata;
  wire [8:0] o_scan_start, o_forced_stop;
  wire [1:0] o_unit_error_irq, o_calibration_done_irq, o_result_overflow_irq, o_composite_match_irq;
  wire [4:0] o_scan_done_irq, o_fifo_read_request_irq;
  wire [3:0] o_compare_match_irq;
  wire [21:0] o_event_link_fabric;
  int err_count = 0, check_count = 0, start_cnt = 0;
  int tgrp[3] = '{0, 3, 8};
  int tbit[3] = '{0, 12, 19};
  always #12.5 i_core_clk = ~i_core_clk;
  atis_far_model m (.i_core_clk, .o_trig_a(i_timer_trigger_out_a),
    .o_trig_b(i_timer_trigger_out_b), .o_pin0_n(i_ext_trigger_pin_0_n),
    .o_pin1_n(i_ext_trigger_pin_1_n));
  atis_trigger_irq dut (.i_core_clk, .i_rst, .i_psel, .i_penable, .i_pwrite, .i_paddr,
    .i_pwdata, .o_prdata, .o_pready, .o_pslverr, .i_timer_trigger_out_a,
    .i_timer_trigger_out_b, .i_ext_trigger_pin_0_n, .i_ext_trigger_pin_1_n, .i_unit_error,
    .i_calibration_done, .i_scan_done, .i_limiter_table_clip, .i_limiter_channel_clip,
    .i_limiter_extended_clip, .i_result_overflow, .i_overflow_channel, .i_overflow_extended,
    .i_compare_table_match, .i_fifo_overflow, .i_fifo_full, .i_fifo_vacant_count,
    .o_scan_start, .o_forced_stop, .o_unit_error_irq, .o_calibration_done_irq,
    .o_scan_done_irq, .o_scan_done_shared_irq, .o_limiter_clip_irq, .o_result_overflow_irq,
    .o_compare_match_irq, .o_composite_match_irq, .o_fifo_read_request_irq,
    .o_fifo_read_request_shared_irq, .o_fifo_overflow_irq, .o_event_link_fabric);
  // start pulses last one cycle, so they are latched here
  always @(posedge i_core_clk) begin
    if (o_scan_start != '0) begin
      last_start <= o_scan_start;
      start_cnt <= start_cnt + 1;
    end
    if (o_forced_stop != '0) last_stop <= o_forced_stop;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge i_core_clk);
    i_psel <= 1'b1;
    i_pwrite <= w;
    i_paddr <= a;
    i_pwdata <= d;
    @(posedge i_core_clk);
    i_penable <= 1'b1;
    do @(posedge i_core_clk); while (o_pready !== 1'b1);
    rd = o_prdata;
    se = o_pslverr;
    i_psel <= 1'b0;
    i_penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
    repeat (3) @(posedge i_core_clk);
  endtask
  task automatic rc(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask
  // codes: 0 err, 1 calibration, 2 scan, 3-4 limiter, 5-6 overflow, 7 compare, 8-9 fifo, else limiter ext
  task automatic ev(input int k, input logic [31:0] v);
    @(posedge i_core_clk);
    case (k)
      0: i_unit_error <= v[1:0];
      1: i_calibration_done <= v[1:0];
      2: i_scan_done <= v[8:0];
      3: i_limiter_table_clip <= v[7:0];
      4: i_limiter_channel_clip <= v[28:0];
      5: i_result_overflow <= v[1:0];
      6: i_overflow_channel <= v[28:0];
      7: i_compare_table_match <= v[7:0];
      8: i_fifo_overflow <= v[8:0];
      9: i_fifo_full <= v[8:0];
      default: i_limiter_extended_clip <= v[8:0];
    endcase
    @(posedge i_core_clk);
    {i_unit_error, i_calibration_done, i_scan_done, i_limiter_table_clip} <= '0;
    {i_limiter_channel_clip, i_result_overflow, i_overflow_channel} <= '0;
    {i_compare_table_match, i_fifo_overflow, i_fifo_full, i_limiter_extended_clip} <= '0;
    repeat (3) @(posedge i_core_clk);
  endtask
  task automatic set_vac(input int lsb, input logic [3:0] v);
    @(posedge i_core_clk);
    i_fifo_vacant_count[lsb+:4] <= v;
    repeat (3) @(posedge i_core_clk);
  endtask
  task automatic print_verdict;
    $display("checks=%0d errors=%0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    #500000;
    err_count++;
    print_verdict;
  end
  initial begin
    int n;
    repeat (16) @(posedge i_core_clk);
    i_rst <= 1'b0;
    rc(`ATIS_OFF_TRIG_EN, 32'h0);
    rc(12'h02C, 32'h0);
    chk(se, 1'b1);
    for (int i = 0; i < 3; i++) begin
      wr(12'(4 * tgrp[i]), 32'h1 << tbit[i]);
      wr(`ATIS_OFF_TRIG_EN, 32'h0);
      n = start_cnt;
      m.pulse(tbit[i] >= 10, tbit[i] % 10);
      repeat (4) @(posedge i_core_clk);
      chk(start_cnt - n, 0);
      wr(`ATIS_OFF_TRIG_EN, 32'h1 << tgrp[i]);
      m.pulse(tbit[i] < 10, tbit[i] % 10);
      repeat (4) @(posedge i_core_clk);
      chk(start_cnt - n, 0);
      m.pulse(tbit[i] >= 10, tbit[i] % 10);
      repeat (4) @(posedge i_core_clk);
      chk(start_cnt - n, 1);
      chk(last_start, 9'h1 << tgrp[i]);
    end
    wr(`ATIS_OFF_TRIG_EN, 32'h0200_0800);
    for (int k = 0; k < 2; k++) begin
      n = start_cnt;
      m.pin(k, 1'b0);
      repeat (20) @(posedge i_core_clk);
      chk(start_cnt - n, 1);
      chk(last_start, k ? 9'h080 : 9'h004);
      m.pin(k, 1'b1);
      repeat (8) @(posedge i_core_clk);
    end
    wr(`ATIS_OFF_IRQ_EN, 32'h003F_FFFD);
    ev(0, 3);
    chk(o_unit_error_irq, 2'b01);
    rc(`ATIS_OFF_UERR, 32'h3);
    repeat (10) @(posedge i_core_clk);
    chk(o_unit_error_irq, 2'b01);
    wr(`ATIS_OFF_UERR, 32'h1);
    chk(o_unit_error_irq, 2'b00);
    ev(1, 2);
    chk(o_calibration_done_irq, 2'b10);
    ev(2, 32'h141);
    chk({o_scan_done_shared_irq, o_scan_done_irq}, 6'h21);
    wr(`ATIS_OFF_SCAN, 32'h101);
    chk({o_scan_done_shared_irq, o_scan_done_irq}, 6'h20);
    wr(`ATIS_OFF_SCAN, 32'h40);
    chk(o_scan_done_shared_irq, 1'b0);
    wr(`ATIS_OFF_STOP, 32'h10);
    chk(last_stop, 9'h010);
    ev(2, 32'h10);
    chk(o_scan_done_irq, 5'h00);
    rc(`ATIS_OFF_SCAN, 32'h0);
    ev(2, 32'h10);
    chk(o_scan_done_irq, 5'h10);
    ev(3, 32'h80);
    chk(o_limiter_clip_irq, 1'b1);
    ev(4, 32'h1000_0000);
    ev(10, 32'h100);
    rc(`ATIS_OFF_LIMC, 32'h1000_0000);
    rc(`ATIS_OFF_LIMX, 32'h100);
    ev(5, 2);
    chk(o_result_overflow_irq, 2'b10);
    ev(6, 1);
    rc(`ATIS_OFF_OVFC, 32'h1);
    ev(7, 32'h08);
    chk(o_compare_match_irq, 4'h8);
    wr(`ATIS_OFF_COMPOSITE, 32'h0002_0330);
    chk(o_composite_match_irq, 2'b00);
    ev(7, 32'h10);
    ev(7, 32'h01);
    chk(o_composite_match_irq, 2'b01);
    ev(7, 32'h02);
    chk(o_composite_match_irq, 2'b11);
    wr(`ATIS_OFF_FIFO_EN, 32'h1FF);
    wr(`ATIS_OFF_THR_LO, 32'h0200_0003);
    set_vac(0, 4'h4);
    chk(o_fifo_read_request_irq, 5'h00);
    set_vac(0, 4'h3);
    chk(o_fifo_read_request_irq, 5'h01);
    set_vac(24, 4'h2);
    chk(o_fifo_read_request_shared_irq, 1'b1);
    ev(9, 1);
    chk(o_fifo_read_request_irq, 5'h00);
    wr(`ATIS_OFF_FERR, 32'h0001_0000);
    chk(o_fifo_read_request_irq, 5'h01);
    ev(8, 32'h100);
    chk(o_fifo_overflow_irq, 1'b1);
    rc(`ATIS_OFF_FERR, 32'h100);
    wr(`ATIS_OFF_IRQ_EN, 32'h0);
    chk(o_unit_error_irq, 2'b00);
    chk(o_event_link_fabric != '0, 1'b1);
    @(posedge i_core_clk);
    i_rst <= 1'b1;
    repeat (4) @(posedge i_core_clk);
    i_rst <= 1'b0;
    chk(o_fifo_overflow_irq, 1'b0);
    rc(`ATIS_OFF_FERR, 32'h0);
    print_verdict;
  end
endmodule // atis_trigger_irq_test
bind atis_trigger_irq atis_trigger_irq_monitor #(.GROUPS(GROUPS), .TIMERS(TIMERS)) mon (
  .i_core_clk, .i_rst, .i_psel, .i_penable, .i_pwrite, .i_paddr, .i_timer_trigger_out_a,
  .i_timer_trigger_out_b, .i_ext_trigger_pin_0_n, .i_ext_trigger_pin_1_n, .i_unit_error,
  .i_scan_done, .i_fifo_full, .i_fifo_overflow, .o_scan_start, .o_forced_stop,
  .o_unit_error_irq, .o_scan_done_shared_irq, .o_fifo_read_request_irq, .o_fifo_overflow_irq);
`default_nettype wire
